// File: rtl/fgr_gain_capture.sv
`timescale 1ns/1ns
`default_nettype none
module fgr_gain_capture
    import fgr_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // active gains from the loop
    input wire logic i_update,
    input wire fgr_gain_pair_t i_gains,
    // packed readback word
    output logic [31:0] o_word
);

    logic [31:0] word;
    logic [31:0] next_word;

    // place each 10-bit gain unchanged in its 16-bit field, upper bits zero
    always_comb begin
        next_word = word;
        if (i_update) begin
            next_word = GAINS_RESET;
            next_word[INTEGRAL_LSB +: GAIN_W] = i_gains.integral;
            next_word[PROPORTIONAL_LSB +: GAIN_W] = i_gains.proportional;
        end
    end

    // hold the last gains the loop reported
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            word <= GAINS_RESET;
        end else begin
            word <= next_word;
        end
    end

    assign o_word = word;

endmodule
`default_nettype wire

// File: rtl/fgr_monitor_scale.sv
`timescale 1ns/1ns
`default_nettype none
module fgr_monitor_scale
    import fgr_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // update enable and settings
    input wire logic i_enable,
    input wire fgr_monitor_ctrl_t i_ctrl,
    // selected variable, normalised to its base value in q15
    input wire logic signed [15:0] i_variable,
    // dac code, 0 to full scale
    output logic [11:0] o_code
);

    logic [11:0] code;
    logic [11:0] next_code;
    logic signed [20:0] product;
    logic signed [20:0] shifted;
    logic signed [20:0] level;
    logic [4:0] enum_value;
    logic [19:0] enum_scaled;
    logic [20:0] enum_level;

    // work out the code that the current settings give
    always_comb begin
        product = i_variable * $signed({1'b0, i_ctrl.fraction_scale});
        if (i_ctrl.polarity_select) begin
            shifted = product >>> UNIPOLAR_SHIFT;
            level = shifted;
        end else begin
            shifted = product >>> BIPOLAR_SHIFT;
            level = shifted + $signed({9'h000, DAC_MID});
        end
        if (i_variable < 0) begin
            enum_value = 5'h00;
        end else if (i_variable > $signed({11'h000, ENUM_MAX})) begin
            enum_value = ENUM_MAX;
        end else begin
            enum_value = i_variable[4:0];
        end
        enum_scaled = {15'h0000, enum_value} << i_ctrl.power_multiplier;
        if (i_ctrl.polarity_select) begin
            enum_level = {1'b0, enum_scaled};
        end else begin
            enum_level = {1'b0, enum_scaled} + {9'h000, DAC_MID};
        end
        next_code = code;
        if (i_enable) begin
            if (i_ctrl.fraction_scale == FRAC_ENUM_CODE) begin
                // enumerated value times two to the multiplier
                if (enum_level > {9'h000, DAC_MAX}) begin
                    next_code = DAC_MAX;
                end else begin
                    next_code = enum_level[11:0];
                end
            end else if (level < 0) begin
                next_code = 12'h000;
            end else if (level > $signed({9'h000, DAC_MAX})) begin
                next_code = DAC_MAX;
            end else begin
                next_code = level[11:0];
            end
        end
    end

    // code register feeding the monitor converter
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            code <= DAC_MID;
        end else begin
            code <= next_code;
        end
    end

    assign o_code = code;

endmodule
`default_nettype wire

// File: rtl/fgr_pkg.sv
package fgr_pkg;

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam logic [7:0] ADDR_CURRENT_GAINS = 8'hF0;
    localparam logic [7:0] ADDR_SPEED_GAINS = 8'hF2;
    localparam logic [7:0] ADDR_MONITOR_CTRL = 8'hF4;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // ----------------------------------------------------------------
    // gain readback fields
    // ----------------------------------------------------------------
    localparam int unsigned GAIN_W = 10;
    localparam int unsigned GAIN_FIELD_W = 16;
    localparam int unsigned INTEGRAL_LSB = 16;
    localparam int unsigned PROPORTIONAL_LSB = 0;
    localparam logic [31:0] GAINS_RESET = 32'h0000_0000;

    // ----------------------------------------------------------------
    // monitor control fields
    // ----------------------------------------------------------------
    localparam int unsigned MULT_LSB = 17;
    localparam int unsigned MULT_MSB = 20;
    localparam int unsigned FRAC_LSB = 13;
    localparam int unsigned FRAC_MSB = 16;
    localparam int unsigned POLARITY_BIT = 12;
    localparam int unsigned POINTER_LSB = 0;
    localparam int unsigned POINTER_MSB = 11;
    localparam logic [31:0] MONITOR_CTRL_RESET = 32'h0011_0000;
    localparam logic [31:0] MONITOR_CTRL_WMASK = 32'h001F_FFFF;

    // ----------------------------------------------------------------
    // monitor conversion
    // ----------------------------------------------------------------
    localparam int unsigned VAR_W = 16;
    localparam int unsigned DAC_W = 12;
    localparam logic [11:0] DAC_MAX = 12'hFFF;
    localparam logic [11:0] DAC_MID = 12'h800;
    localparam logic [3:0] FRAC_ENUM_CODE = 4'h0;
    localparam logic [4:0] ENUM_MAX = 5'h1F;
    localparam int unsigned UNIPOLAR_SHIFT = 6;
    localparam int unsigned BIPOLAR_SHIFT = 7;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 50;
    localparam int unsigned MON_UPDATE_NS = 1000;
    localparam int unsigned MON_UPDATE_CYCLES = (MON_UPDATE_NS * CLK_MHZ) / 1000;
    localparam int unsigned MON_CNT_W = 6;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [9:0] integral;
        logic [9:0] proportional;
    } fgr_gain_pair_t;

    typedef struct packed {
        logic [3:0] power_multiplier;
        logic [3:0] fraction_scale;
        logic polarity_select;
        logic [11:0] variable_pointer;
    } fgr_monitor_ctrl_t;

endpackage

// File: rtl/fgr_register_bank.sv
`timescale 1ns/1ns
`default_nettype none
module fgr_register_bank
    import fgr_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // active gains from the current and speed loops
    input wire logic i_current_gain_update,
    input wire fgr_gain_pair_t i_current_gains,
    input wire logic i_speed_gain_update,
    input wire fgr_gain_pair_t i_speed_gains,
    // first analog monitor
    input wire logic signed [15:0] i_monitor_variable,
    output logic [11:0] o_monitor_one_variable_pointer,
    output logic [11:0] o_analog_monitor_output_one,
    output logic o_monitor_update
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    fgr_monitor_ctrl_t monitor_ctrl;
    fgr_monitor_ctrl_t next_monitor_ctrl;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [5:0] update_count;
    logic [5:0] next_update_count;
    logic update_tick;
    logic [31:0] current_word;
    logic [31:0] speed_word;
    logic [31:0] monitor_word;
    logic [1:0] gain_update;
    fgr_gain_pair_t gain_in [2];
    logic [31:0] gain_word [2];

    // ----------------------------------------------------------------
    // gain readback
    // ----------------------------------------------------------------
    // channel 0 is the current loop, channel 1 the speed loop
    assign gain_update = {i_speed_gain_update, i_current_gain_update};
    assign gain_in[0] = i_current_gains;
    assign gain_in[1] = i_speed_gains;

    // gains pass through with no rescaling, so the encoding matches setup
    for (genvar ch = 0; ch < 2; ch++) begin : g_gain_channel
        fgr_gain_capture u_gains (
            .i_clk_sys(i_clk_sys),
            .i_rst(i_rst),
            .i_update(gain_update[ch]),
            .i_gains(gain_in[ch]),
            .o_word(gain_word[ch])
        );
    end

    // readback words by loop
    assign current_word = gain_word[0];
    assign speed_word = gain_word[1];

    // ----------------------------------------------------------------
    // monitor control register
    // ----------------------------------------------------------------
    // only the monitor control word is writable; other offsets drop writes
    always_comb begin
        next_monitor_ctrl = monitor_ctrl;
        if (i_wr && (i_addr == ADDR_MONITOR_CTRL)) begin
            next_monitor_ctrl.power_multiplier = i_wdata[MULT_MSB:MULT_LSB];
            next_monitor_ctrl.fraction_scale = i_wdata[FRAC_MSB:FRAC_LSB];
            next_monitor_ctrl.polarity_select = i_wdata[POLARITY_BIT];
            next_monitor_ctrl.variable_pointer = i_wdata[POINTER_MSB:POINTER_LSB];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            monitor_ctrl <= fgr_monitor_ctrl_t'(MONITOR_CTRL_RESET[20:0]);
        end else begin
            monitor_ctrl <= next_monitor_ctrl;
        end
    end

    // reserved bits 31-21 always read zero
    assign monitor_word = {11'h000, monitor_ctrl} & MONITOR_CTRL_WMASK;

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // read data stand only in the cycle after the strobe
    always_comb begin
        next_rdata = UNMAPPED_READ;
        if (i_rd) begin
            case (i_addr)
                ADDR_CURRENT_GAINS: next_rdata = current_word;
                ADDR_SPEED_GAINS: next_rdata = speed_word;
                ADDR_MONITOR_CTRL: next_rdata = monitor_word;
                default: next_rdata = UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            rdata <= UNMAPPED_READ;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign o_rdata = rdata;

    // ----------------------------------------------------------------
    // monitor update rate
    // ----------------------------------------------------------------
    // one-cycle enable every update period refreshes the converter code
    always_comb begin
        update_tick = (update_count == 6'(MON_UPDATE_CYCLES - 1));
        if (update_tick) begin
            next_update_count = 6'h00;
        end else begin
            next_update_count = update_count + 6'h01;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            update_count <= 6'h00;
        end else begin
            update_count <= next_update_count;
        end
    end

    // ----------------------------------------------------------------
    // monitor conversion
    // ----------------------------------------------------------------
    // the variable arrives normalised to its base (current, speed, bus or
    // phase voltage), so one conversion serves every kind of quantity
    fgr_monitor_scale u_monitor_scale (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_enable(update_tick),
        .i_ctrl(monitor_ctrl),
        .i_variable(i_monitor_variable),
        .o_code(o_analog_monitor_output_one)
    );

    assign o_monitor_one_variable_pointer = monitor_ctrl.variable_pointer;
    assign o_monitor_update = update_tick;

endmodule
`default_nettype wire

// File: sim/fgr_register_bank_props.sv
`timescale 1ns/1ns
`default_nettype none
module fgr_register_bank_props
    import fgr_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    // active gains
    input wire logic i_current_gain_update,
    input wire fgr_gain_pair_t i_current_gains,
    input wire logic i_speed_gain_update,
    input wire fgr_gain_pair_t i_speed_gains,
    // first analog monitor
    input wire logic signed [15:0] i_monitor_variable,
    input wire logic [11:0] o_monitor_one_variable_pointer,
    input wire logic [11:0] o_analog_monitor_output_one,
    input wire logic o_monitor_update
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    // ------------------------------------------------------------
    // expected control word
    // ------------------------------------------------------------
    logic [31:0] shadow;
    logic [31:0] next_shadow;

    // mirror writes to the control register, reserved bits masked
    always_comb begin
        next_shadow = shadow;
        if (i_wr && i_addr == 8'hF4) begin
            next_shadow = i_wdata & 32'h001F_FFFF;
        end
    end

    // register the mirror
    always_ff @(posedge i_clk_sys) begin
        shadow <= i_rst ? 32'h0011_0000 : next_shadow;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    chk_unmapped_zero: assert property (i_rd && !(i_addr inside {8'hF0, 8'hF2, 8'hF4})
        |=> o_rdata == 32'h0) else $error("unmapped read returned data");
    chk_current_word: assert property (i_current_gain_update
        ##1 (i_rd && i_addr == 8'hF0 && !i_current_gain_update)
        |=> o_rdata == {6'h0, $past(i_current_gains.integral, 2),
        6'h0, $past(i_current_gains.proportional, 2)}) else $error("current gain word wrong");
    chk_speed_word: assert property (i_speed_gain_update
        ##1 (i_rd && i_addr == 8'hF2 && !i_speed_gain_update)
        |=> o_rdata == {6'h0, $past(i_speed_gains.integral, 2),
        6'h0, $past(i_speed_gains.proportional, 2)}) else $error("speed gain word wrong");
    chk_ctrl_read: assert property (i_rd && i_addr == 8'hF4
        |=> o_rdata == $past(shadow)) else $error("control readback wrong");
    chk_update_period: assert property (o_monitor_update
        |=> !o_monitor_update ##49 o_monitor_update) else $error("update pulse spacing wrong");
    chk_code_hold: assert property (!$past(o_monitor_update) && !$past(i_rst)
        |-> $stable(o_analog_monitor_output_one)) else $error("code moved between updates");
    chk_enum_bipolar: assert property (o_monitor_update && shadow[20:12] == 9'h000
        && i_monitor_variable inside {[0:31]}
        |=> o_analog_monitor_output_one - 12'h800 == 12'($past(i_monitor_variable)))
        else $error("enum bipolar code wrong");
    chk_frac_unipolar: assert property (o_monitor_update && shadow[16:12] == 5'h11
        && !i_monitor_variable[15]
        |=> o_analog_monitor_output_one == 12'($past(i_monitor_variable) >>> 3))
        else $error("fraction unipolar code wrong");
    chk_mult_unipolar: assert property (o_monitor_update && shadow[20:12] == 9'h041
        && i_monitor_variable inside {[0:31]}
        |=> o_analog_monitor_output_one == 12'($past(i_monitor_variable)) << 2)
        else $error("multiplier code wrong");

    // main scenarios reached
    cover property (o_monitor_update && shadow[16:13] == 4'h0);
    cover property (i_wr && i_addr == 8'hF4);
    cover property (i_current_gain_update ##1 (i_rd && i_addr == 8'hF0));
endmodule
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
    import fgr_pkg::*;
;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [15:0] v;
        logic [11:0] code;
    } fgr_row_t;

    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic i_current_gain_update = 1'b0;
    fgr_gain_pair_t i_current_gains = '0;
    logic i_speed_gain_update = 1'b0;
    fgr_gain_pair_t i_speed_gains = '0;
    logic signed [15:0] i_monitor_variable = 16'sh0;
    logic [11:0] o_monitor_one_variable_pointer;
    logic [11:0] o_analog_monitor_output_one;
    logic o_monitor_update;
    int fails = 0;
    int checks_done = 0;
    // control word, variable, expected code; scales 2/8, 7/8, 8/8 as advised, and 15/8
    fgr_row_t rows [12] = '{
        '{32'h001F_1123, 16'h1000, 12'h200}, '{32'h0001_0000, 16'h1000, 12'h900},
        '{32'h0000_4000, 16'hF000, 12'h7C0}, '{32'h0001_1000, 16'h7FFF, 12'hFFF},
        '{32'h0001_F000, 16'h7FFF, 12'hFFF}, '{32'h0001_1000, 16'hFF00, 12'h000},
        '{32'h0004_1000, 16'h0005, 12'h014}, '{32'h0000_0000, 16'h0028, 12'h81F},
        '{32'h0000_0000, 16'h0007, 12'h807}, '{32'h0010_1000, 16'h001F, 12'hFFF},
        '{32'h0000_1000, 16'hFFFD, 12'h000}, '{32'h0000_E000, 16'h4000, 12'hB80}};

    fgr_register_bank i_fgr_register_bank (.*);

    // free-running system clock
    always #10 i_clk_sys = ~i_clk_sys;

    // ------------------------------------------------------------
    // compare, bus and monitor tasks
    // ------------------------------------------------------------
    task automatic results;
        if (fails == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask

    // read strobe also ends any gain capture strobe, so capture and read abut
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge i_clk_sys);
        i_current_gain_update <= 1'b0;
        i_speed_gain_update <= 1'b0;
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        @(negedge i_clk_sys);
        chk(name, exp, o_rdata);
    endtask

    // program the monitor, wait for the refresh pulse, check the new code
    task automatic mon(input logic [31:0] ctrl, input logic [15:0] v, input logic [11:0] exp);
        int n;
        n = 0;
        i_monitor_variable <= v;
        wr(8'hF4, ctrl);
        do begin
            @(negedge i_clk_sys);
            n++;
        end while (o_monitor_update !== 1'b1 && n < 60);
        if (o_monitor_update !== 1'b1) begin
            fails++;
            results();
        end
        @(negedge i_clk_sys);
        chk("monitor code", exp, 32'(o_analog_monitor_output_one));
        chk("pointer", 32'(ctrl[11:0]), 32'(o_monitor_one_variable_pointer));
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        foreach (rows[i]) begin
            mon(rows[i].ctrl, rows[i].v,
                rows[i].code);
        end
        // capture gains, then read back in the very next cycle
        @(posedge i_clk_sys);
        i_current_gain_update <= 1'b1;
        i_current_gains <= 20'hFFD55;
        rd(8'hF0, 32'h03FF_0155, "current gains");
        @(posedge i_clk_sys);
        i_speed_gain_update <= 1'b1;
        i_speed_gains <= 20'h002AA;
        rd(8'hF2, 32'h0000_02AA, "speed gains");
        // no strobe and bus writes: readback must not move
        i_current_gains <= 20'h00000;
        wr(8'hF0, 32'hFFFF_FFFF);
        wr(8'hF2, 32'hFFFF_FFFF);
        rd(8'hF0, 32'h03FF_0155, "current after write");
        rd(8'hF2, 32'h0000_02AA, "speed after write");
        wr(8'hF4, 32'hFFFF_FFFF);
        rd(8'hF4, 32'h001F_FFFF, "control reserved");
        wr(8'h10, 32'h1234_5678);
        rd(8'h10, 32'h0, "unmapped");
        // every fraction code and every multiplier code
        for (int k = 0; k < 16; k++) begin
            if (k > 0) begin
                mon(32'h0000_1000 | 32'(k << 13), 16'h0800, 12'(k * 32));
            end
            mon(32'h0000_1000 | 32'(k << 17), 16'h0001,
                (k < 12) ? 12'(1 << k) : 12'hFFF);
        end
        // reset in mid-run
        @(posedge i_clk_sys);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        @(negedge i_clk_sys);
        chk("reset code", 32'h0000_0800, 32'(o_analog_monitor_output_one));
        rd(8'hF0, 32'h0, "current reset");
        rd(8'hF2, 32'h0, "speed reset");
        rd(8'hF4, 32'h0011_0000, "control reset");
        results();
    end
endmodule

bind fgr_register_bank fgr_register_bank_props i_props (.*);
`default_nettype wire
